/* File: logic/stream_in_pkg.sv */
/*
  Shared constants and carriers for the host stream IN move-data engine.
  Assumes a 40 MHz aclk, synchronous active-low reset, AXI4-Lite registers.
*/
package stream_in_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STREAM_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] RETRY_OFF = 8'h0C;
  localparam logic [7:0] COUNT_OFF = 8'h10;
  // Control field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_HIMD = 1;
  localparam int CTRL_FORCE_END = 2;
  localparam int CTRL_RESUME = 3;
  localparam int CTRL_BUF_OK = 4;
  localparam int CTRL_CLR_ERR = 5;
  // Reset values and the packet count carried in acks
  localparam logic [3:0] RETRY_LIMIT_RST = 4'h3;
  localparam logic [15:0] NO_STREAM = 16'h0000;
  localparam logic [4:0] NUMP_BURST = 5'h04;
  localparam logic [15:0] BUF_PKTS_RST = 16'h0000;

  // Packet types seen or sent on the link
  typedef enum logic [2:0] {
    PK_NONE, PK_DP, PK_ACK, PK_NRDY, PK_ERDY
  } pkt_kind_t;

  // Inbound packet summary from the link decoder
  typedef struct packed {
    pkt_kind_t kind;
    logic [15:0] sid;
    logic eob;
    logic deferred;
    logic bad;
  } rx_pkt_t;

  // Outbound acknowledgement request
  typedef struct packed {
    logic [15:0] sid;
    logic [4:0] nump;
    logic pp;
    logic rty;
  } tx_ack_t;

  // Move-data substates
  typedef enum logic [2:0] {
    MD_IDLE, MD_WAIT_DP, MD_HOST_ACK, MD_BURST_END, MD_DEV_TERM
  } md_state_t;
endpackage

/* File: logic/retry_counter.sv */
/*
  Per-pipe retry budget: loads a limit, counts down on each retry.
  Assumes load and use never coincide with reset.
*/
module retry_counter
  import stream_in_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic load,
  input wire logic [3:0] limit,
  input wire logic use_one,
  // Status
  output logic exhausted
);
  logic [3:0] left_r;

  // Countdown, reloaded on each good packet or new transfer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_r <= RETRY_LIMIT_RST;
    end else if (load) begin
      left_r <= limit;
    end else if (use_one && left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
    end
  end

  assign exhausted = (left_r == 4'h0);
endmodule

/* File: logic/axil_regs.sv */
/*
  AXI4-Lite slave for the move-data engine: write pulses and read mux.
  Assumes one write and one read outstanding at a time.
*/
module axil_regs
  import stream_in_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);
  logic aw_have_r, w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;

  // Accept address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
    end else if (wr_en) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_r <= 1'b1;
        w_data_r <= wdata;
      end
    end
  end

  assign awready = !aw_have_r && !bvalid;
  assign wready = !w_have_r && !bvalid;
  assign wr_en = aw_have_r && w_have_r;
  assign wr_addr = aw_addr_r;
  assign wr_data = w_data_r;

  // Write response, OKAY always
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
    end else if (wr_en) begin
      bvalid <= 1'b1;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end
  assign bresp = 2'h0;

  // Read channel, SLVERR on unmapped address
  assign arready = !rvalid;
  assign rd_addr = araddr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_hit ? rd_data : 32'h0000_0000;
      rresp <= rd_hit ? 2'h0 : 2'h2;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

/* File: logic/stream_in_move.sv */
/*
  Host side of the bulk IN stream move-data phase: waits for data packets,
  copies them to the endpoint buffer and answers with paced acknowledgements.
  Assumes a link decoder that presents each inbound packet for one cycle at
  the moment it is first decoded, and a link encoder that takes an ack
  request on the cycle it is strobed.
*/
module stream_in_move
  import stream_in_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register port
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Inbound packets from link decoder
  input wire logic rx_valid,
  input wire rx_pkt_t rx_pkt,
  // Outbound acknowledgement request
  output logic tx_valid,
  output tx_ack_t tx_ack,
  // Buffer write strobe for the received payload
  output logic buf_wr,
  output logic [15:0] buf_sid,
  // Pipe halt and status
  output logic halt,
  output logic in_move
);
  md_state_t state_r;
  logic [15:0] cstream_r, lcstream_r, start_sid_r, buf_pkts_r;
  logic [3:0] retry_limit_r;
  logic rty_r, force_end_r, resume_r, start_r, himd_r, buf_ok_r;
  logic halt_r, sid_err_r, retry_err_r;
  logic [15:0] pkt_count_r;
  logic wr_en, rd_hit, exhausted, retry_load, retry_use;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic rx_dp, rx_nrdy, rx_erdy, rx_def, sid_ok, buf_left, tx_go;
  tx_ack_t ack_nxt;
  md_state_t state_nxt;

  axil_regs u_regs (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit)
  );

  retry_counter u_retry (
    .aclk(aclk), .aresetn(aresetn),
    .load(retry_load), .limit(retry_limit_r),
    .use_one(retry_use), .exhausted(exhausted)
  );

  // Decoded packet classes
  assign rx_dp = rx_valid && rx_pkt.kind == PK_DP;
  assign rx_nrdy = rx_valid && rx_pkt.kind == PK_NRDY;
  assign rx_erdy = rx_valid && rx_pkt.kind == PK_ERDY;
  assign rx_def = rx_valid && rx_pkt.kind == PK_ACK && rx_pkt.deferred;
  assign sid_ok = rx_pkt.sid == cstream_r;
  assign buf_left = buf_pkts_r > 16'h0001;

  // Control strobes and held settings written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_r <= 1'b0;
      himd_r <= 1'b0;
      force_end_r <= 1'b0;
      resume_r <= 1'b0;
      buf_ok_r <= 1'b0;
      start_sid_r <= NO_STREAM;
      retry_limit_r <= RETRY_LIMIT_RST;
    end else begin
      start_r <= 1'b0;
      resume_r <= 1'b0;
      if (wr_en && wr_addr == CTRL_OFF) begin
        start_r <= wr_data[CTRL_START];
        himd_r <= wr_data[CTRL_HIMD];
        force_end_r <= wr_data[CTRL_FORCE_END];
        resume_r <= wr_data[CTRL_RESUME];
        buf_ok_r <= wr_data[CTRL_BUF_OK];
      end
      if (wr_en && wr_addr == STREAM_OFF) begin
        start_sid_r <= wr_data[15:0];
      end
      if (wr_en && wr_addr == RETRY_OFF) begin
        retry_limit_r <= wr_data[3:0];
      end
    end
  end

  // Next state and acknowledgement, at most one answer per decoded packet
  always_comb begin
    state_nxt = state_r;
    ack_nxt = '{sid: cstream_r, nump: NUMP_BURST, pp: 1'b1, rty: rty_r};
    tx_go = 1'b0;
    retry_use = 1'b0;
    unique case (state_r)
      MD_IDLE: begin
        if (start_r && buf_ok_r && !halt_r) begin
          state_nxt = MD_WAIT_DP;
        end
      end
      MD_WAIT_DP: begin
        if (rx_dp && sid_ok) begin
          state_nxt = rx_pkt.eob ? MD_DEV_TERM : MD_HOST_ACK;
        end else if (rx_nrdy && sid_ok) begin
          state_nxt = MD_IDLE;
        end else if (rx_def) begin
          state_nxt = MD_IDLE;
        end
        // An ERDY here is a crossing race and is ignored
      end
      MD_HOST_ACK: begin
        tx_go = 1'b1;
        ack_nxt.rty = rty_r;
        retry_use = rty_r;
        if (!rty_r && !buf_left) begin
          ack_nxt.nump = 5'h00;
          ack_nxt.pp = 1'b0;
          state_nxt = MD_IDLE;
        end else if (force_end_r) begin
          ack_nxt.nump = 5'h00;
          state_nxt = MD_BURST_END;
        end else begin
          state_nxt = MD_WAIT_DP;
        end
      end
      MD_BURST_END: begin
        if (resume_r) begin
          tx_go = 1'b1;
          state_nxt = MD_WAIT_DP;
        end
      end
      MD_DEV_TERM: begin
        tx_go = 1'b1;
        retry_use = rty_r;
        if (!rty_r) begin
          ack_nxt.nump = 5'h00;
          ack_nxt.rty = 1'b0;
          state_nxt = MD_IDLE;
        end else if (force_end_r) begin
          ack_nxt.nump = 5'h00;
          state_nxt = MD_BURST_END;
        end else begin
          state_nxt = MD_WAIT_DP;
        end
      end
      default: state_nxt = MD_IDLE;
    endcase
    if (state_r != MD_IDLE && (halt_r || (retry_use && exhausted))) begin
      state_nxt = MD_IDLE;
      tx_go = 1'b0;
    end
  end

  // Retry budget reloads on a new transfer or a good packet
  assign retry_load = (state_r == MD_IDLE) || (rx_dp && !rx_pkt.bad);

  // State register, change taken at decode or send cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= MD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Stream bookkeeping and retry flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cstream_r <= NO_STREAM;
      lcstream_r <= NO_STREAM;
      rty_r <= 1'b0;
    end else begin
      if (state_r == MD_IDLE && state_nxt == MD_WAIT_DP) begin
        cstream_r <= start_sid_r;
        rty_r <= 1'b0;
      end
      if (state_r == MD_WAIT_DP && rx_dp && sid_ok) begin
        lcstream_r <= cstream_r;
        rty_r <= rx_pkt.bad;
      end
    end
  end

  // Endpoint buffer space in packets, loaded by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_pkts_r <= BUF_PKTS_RST;
    end else if (wr_en && wr_addr == COUNT_OFF) begin
      buf_pkts_r <= wr_data[15:0];
    end else if (buf_wr && buf_pkts_r != 16'h0000) begin
      buf_pkts_r <= buf_pkts_r - 16'h0001;
    end
  end

  // Halt on stream mismatch or exhausted retries; set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sid_err_r <= 1'b0;
      retry_err_r <= 1'b0;
      halt_r <= 1'b0;
    end else begin
      if (state_r == MD_WAIT_DP && rx_valid && !rx_erdy && !rx_def &&
          !sid_ok) begin
        sid_err_r <= 1'b1;
        halt_r <= 1'b1;
      end else if (state_r != MD_IDLE && retry_use && exhausted) begin
        retry_err_r <= 1'b1;
        halt_r <= 1'b1;
      end else if (wr_en && wr_addr == CTRL_OFF && wr_data[CTRL_CLR_ERR]) begin
        sid_err_r <= 1'b0;
        retry_err_r <= 1'b0;
        halt_r <= 1'b0;
      end
    end
  end

  // Outputs from flops: ack request and buffer write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid <= 1'b0;
      tx_ack <= '0;
      buf_wr <= 1'b0;
      buf_sid <= NO_STREAM;
      halt <= 1'b0;
      in_move <= 1'b0;
      pkt_count_r <= 16'h0000;
    end else begin
      tx_valid <= tx_go;
      if (tx_go) begin
        tx_ack <= ack_nxt;
      end
      buf_wr <= state_r == MD_WAIT_DP && rx_dp && sid_ok && !rx_pkt.bad;
      buf_sid <= cstream_r;
      halt <= halt_r;
      in_move <= state_nxt != MD_IDLE;
      if (buf_wr) begin
        pkt_count_r <= pkt_count_r + 16'h0001;
      end
    end
  end

  // Register read mux
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      CTRL_OFF: rd_data = {27'h0, buf_ok_r, force_end_r, 1'b0, himd_r, 1'b0};
      STREAM_OFF: rd_data = {lcstream_r, cstream_r};
      STATUS_OFF: rd_data = {16'h0, pkt_count_r[7:0], 1'b0,
                             retry_err_r, sid_err_r, halt_r, rty_r,
                             state_r};
      RETRY_OFF: rd_data = {28'h0, retry_limit_r};
      COUNT_OFF: rd_data = {16'h0, buf_pkts_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // Exits never carry the retry flag
  a_exit_no_retry: assert property (
    @(posedge aclk) disable iff (!aresetn)
    tx_valid && tx_ack.nump == 5'h00 && !tx_ack.pp |-> !tx_ack.rty)
    else $error("exit ack carries retry");
  // Entry lands in wait-for-data
  a_entry_wait: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_r == MD_IDLE && start_r && buf_ok_r && !halt_r
    |=> state_r == MD_WAIT_DP)
    else $error("entry not to wait");
  // No entry without buffers
  a_no_buf_stay: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_r == MD_IDLE && !buf_ok_r |=> state_r == MD_IDLE)
    else $error("entered without buffers");
  // Erdy race keeps waiting
  a_erdy_race: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_r == MD_WAIT_DP && rx_erdy && !halt_r |=> state_r == MD_WAIT_DP)
    else $error("erdy left wait");
  // Not-ready exits
  a_nrdy_exit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_r == MD_WAIT_DP && rx_nrdy && sid_ok |=> state_r == MD_IDLE)
    else $error("nrdy did not exit");
  // Deferred exits
  a_defer_exit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_r == MD_WAIT_DP && rx_def |=> state_r == MD_IDLE)
    else $error("deferred did not exit");
  // Good end-of-burst data yields a final ack two cycles later
  a_term_ack: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_r == MD_WAIT_DP && rx_dp && sid_ok && rx_pkt.eob && !rx_pkt.bad
    && !halt_r |=> ##1 tx_valid && tx_ack.nump == 5'h00 && !tx_ack.rty)
    else $error("no final ack");
  // Data records last stream
  a_lcstream: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_r == MD_WAIT_DP && rx_dp && sid_ok
    |=> lcstream_r == $past(cstream_r))
    else $error("last stream not updated");
  // Burst-end resume ack
  a_resume_ack: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_r == MD_BURST_END && resume_r && !halt_r
    |=> tx_valid && tx_ack.nump != 5'h00 && tx_ack.pp)
    else $error("resume ack wrong");
endmodule

/* File: bench/stream_in_partner.sv */
/*
  Peripheral stream IN endpoint model: sends packets on request and
  tallies acknowledgements and buffer copies from the host engine.
  Assumes the bench calls send after a clock edge, one packet at a time.
*/
module stream_in_partner
  import stream_in_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Host outputs
  input wire logic tx_valid,
  input wire tx_ack_t tx_ack,
  input wire logic buf_wr,
  // Packets to host
  output logic rx_valid,
  output rx_pkt_t rx_pkt
);
  timeunit 1ns;
  timeprecision 1ps;
  int acks = 0;
  int bufs = 0;
  tx_ack_t last;

  // Tally acks and buffer copies
  always @(posedge aclk) begin
    if (tx_valid === 1'b1) begin
      acks <= acks + 1;
      last <= tx_ack;
    end
    if (buf_wr === 1'b1) bufs <= bufs + 1;
  end

  initial begin
    rx_valid = 1'b0;
    rx_pkt = '0;
  end

  // One-cycle packet; idle cycles scramble the summary bus
  task pulse(input rx_pkt_t p, input int gap);
    repeat (gap) begin
      @(posedge aclk);
      rx_pkt <= rx_pkt_t'(~rx_pkt);
    end
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_pkt <= p;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_pkt <= rx_pkt_t'(~p);
  endtask

  task send(input pkt_kind_t k, input logic [15:0] sid,
            input logic eob, df, bad, input int gap);
    pulse('{k, sid, eob, df, bad}, gap);
    // A deferred ack counts as priming: restart the stream later
    if (k == PK_ACK && df) pulse('{PK_ERDY, sid, 1'b0, 1'b0, 1'b0}, 4);
  endtask
endmodule

/* File: bench/stream_in_move_tb.sv */
/*
  Self-checking bench for stream_in_move: register tasks, packet traffic
  through the partner model, and the verdict.
  Assumes the partner model owns the inbound packet port.
*/
module stream_in_move_tb
  import stream_in_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [22:0] ALL = 23'h7FFFFF;
  localparam logic [22:0] NO_PP = 23'h7FFFFD;
  localparam logic [31:0] BUF = 32'h1 << CTRL_BUF_OK;
  localparam logic [31:0] GO = 32'h1 << CTRL_START;
  localparam logic [31:0] FEND = 32'h1 << CTRL_FORCE_END;
  localparam logic [31:0] RES = 32'h1 << CTRL_RESUME;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rr;
  logic rx_valid, tx_valid, buf_wr, halt, in_move;
  rx_pkt_t rx_pkt;
  tx_ack_t tx_ack;
  logic [15:0] buf_sid, s;
  int fail_count = 0;
  int compares = 0;
  int n0;

  // Clock
  always #12.5 aclk = ~aclk;

  stream_in_move stream_in_move_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .rx_valid(rx_valid),
    .rx_pkt(rx_pkt), .tx_valid(tx_valid), .tx_ack(tx_ack), .buf_wr(buf_wr),
    .buf_sid(buf_sid), .halt(halt), .in_move(in_move));

  stream_in_partner stream_in_partner_i (
    .aclk(aclk), .tx_valid(tx_valid), .tx_ack(tx_ack), .buf_wr(buf_wr),
    .rx_valid(rx_valid), .rx_pkt(rx_pkt));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task rst;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
  endtask

  // Write: address and data offered together, each dropped when taken
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ad = ad | (awvalid & awready);
      wd = wd | (wvalid & wready);
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1) @(negedge aclk);
    rr = bresp;
    @(posedge aclk);
    bready <= 1'b0;
    @(negedge aclk);
  endtask

  // Read: address held until taken, data taken with rvalid
  task axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    @(posedge aclk);
    rready <= 1'b0;
    @(negedge aclk);
  endtask

  // Expected acknowledgement for the current stream
  function automatic tx_ack_t mk(input logic nz, pp, rty);
    return '{s, nz ? NUMP_BURST : 5'h00, pp, rty};
  endfunction

  task wait_ack(input int a0, input tx_ack_t e, input logic [22:0] m);
    int n;
    n = 0;
    while (stream_in_partner_i.acks == a0 && n < 40) begin
      @(negedge aclk);
      n++;
    end
    chk(n < 40, 1'b1);
    chk(32'(stream_in_partner_i.last & m), 32'(e & m));
  endtask

  // Data packet from the peripheral, then its acknowledgement
  task dp(input logic eob, bad, input tx_ack_t e, input logic [22:0] m);
    int a0, b0;
    a0 = stream_in_partner_i.acks;
    b0 = stream_in_partner_i.bufs;
    stream_in_partner_i.send(PK_DP, s, eob, 1'b0, bad, $urandom_range(3));
    wait_ack(a0, e, m);
    chk(stream_in_partner_i.bufs - b0, !bad);
    chk(buf_sid, s);
  endtask

  // Pick a stream and start move data
  task start(input logic ok);
    s = 16'($urandom_range(16'hFFFF, 1));
    axw(STREAM_OFF, {16'h0000, s});
    axw(CTRL_OFF, (ok ? BUF : 32'h0) | GO | ($urandom_range(1) << CTRL_HIMD));
    axr(STATUS_OFF);
    chk({in_move, rd[2:0]}, {ok, 2'b00, ok});
  endtask

  // Main sequence
  initial begin
    logic bad;
    int n;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    void'($urandom(32'hEB2FF8E4));
    rst();
    chk({halt, in_move, tx_valid, buf_wr}, 4'h0);
    axr(RETRY_OFF);
    chk(rd, {28'h0, RETRY_LIMIT_RST});
    axr(STREAM_OFF);
    chk(rd, {NO_STREAM, NO_STREAM});
    axr(8'h20);
    chk({rr, rd[29:0]}, 32'h80000000);
    axw(8'h20, 32'hFFFFFFFF);
    chk(rr, 2'b00);
    axw(COUNT_OFF, 32'h40);
    axw(RETRY_OFF, 32'h4);
    start(1'b0);
    start(1'b1);
    repeat ($urandom_range(3, 1)) begin
      bad = 1'($urandom_range(1));
      dp(1'b0, bad, mk(1'b1, 1'b1, bad), ALL);
    end
    axr(STREAM_OFF);
    chk(rd, {s, s});
    stream_in_partner_i.send(PK_ERDY, s ^ 16'h0100, 1'b0, 1'b0, 1'b0, 0);
    axr(STATUS_OFF);
    chk({halt, in_move, rd[2:0]}, 5'h09);
    dp(1'b1, 1'b1, mk(1'b1, 1'b1, 1'b1), ALL);
    dp(1'b1, 1'b0, mk(1'b0, 1'b0, 1'b0), NO_PP);
    axr(STATUS_OFF);
    chk({in_move, rd[3:0]}, 5'h00);
    for (int k = 0; k < 2; k++) begin
      start(1'b1);
      stream_in_partner_i.send(k ? PK_ACK : PK_NRDY, s, 1'b0, k[0], 1'b0, 1);
      axr(STATUS_OFF);
      chk({in_move, rd[3:0]}, 5'h00);
    end
    start(1'b1);
    axw(CTRL_OFF, BUF | FEND);
    dp(1'b0, 1'b0, mk(1'b0, 1'b1, 1'b0), ALL);
    axr(STATUS_OFF);
    chk({in_move, rd[2:0]}, 4'hB);
    n0 = stream_in_partner_i.acks;
    axw(CTRL_OFF, BUF | RES);
    wait_ack(n0, mk(1'b1, 1'b1, 1'b0), ALL);
    axw(CTRL_OFF, BUF | FEND);
    dp(1'b1, 1'b1, mk(1'b0, 1'b1, 1'b1), ALL);
    axr(STATUS_OFF);
    chk({in_move, rd[3:0]}, 5'h1B);
    n0 = stream_in_partner_i.acks;
    axw(CTRL_OFF, BUF | RES);
    wait_ack(n0, mk(1'b1, 1'b1, 1'b1), ALL);
    dp(1'b1, 1'b0, mk(1'b0, 1'b0, 1'b0), NO_PP);
    axw(COUNT_OFF, 32'h1);
    start(1'b1);
    dp(1'b0, 1'b0, mk(1'b0, 1'b0, 1'b0), ALL);
    axr(STATUS_OFF);
    chk({in_move, rd[2:0]}, 4'h0);
    axw(COUNT_OFF, 32'h40);
    start(1'b1);
    stream_in_partner_i.send(PK_DP, s ^ 16'h0001, 1'b0, 1'b0, 1'b0, 0);
    repeat (4) @(negedge aclk);
    chk(halt, 1'b1);
    axr(STATUS_OFF);
    chk({rd[5:4], rd[2:0]}, 5'h18);
    axw(CTRL_OFF, 32'h1 << CTRL_CLR_ERR);
    chk(halt, 1'b0);
    rst();
    chk({halt, in_move}, 2'b00);
    axw(COUNT_OFF, 32'h40);
    axw(RETRY_OFF, 32'h2);
    start(1'b1);
    n = 0;
    while (halt !== 1'b1 && n < 8) begin
      stream_in_partner_i.send(PK_DP, s, 1'b0, 1'b0, 1'b1, $urandom_range(2));
      repeat (6) @(negedge aclk);
      n++;
    end
    axr(STATUS_OFF);
    chk({halt, in_move, rd[6], rd[2:0]}, 6'h28);
    chk(n inside {[2:3]}, 1'b1);
    results();
  end

  // Watchdog
  initial begin
    #500000;
    fail_count++;
    results();
  end
endmodule
